/* File: hdl/sps_top.sv */
// Contract
// - Slave only; the master owns the clock and starts every byte.
// - Mode zero: clock idles low, both lines sampled on rising edge.
// - Bytes cross most significant bit first in both directions.
// - Drive output while selected, release it while select is high; the link only drives it from the first falling clock edge.
// - Attention low from data queued until the master clocked it out.
// - Attention output is always driven, never high impedance.
// - Full duplex; bytes outside frames are ignored by the receiver; the core passes on every byte received while SPI is the locked port.
// - Outgoing data may start before, with or during incoming data.
// - SPI uses unescaped API mode one; API mode setting is UART only.
// - Sleep request pin as peripheral controls pin sleep for both ports.
// - Else select as peripheral: low wakes, high sleeps.
// - Neither pin a peripheral: stay awake despite pin sleep setting.
// - SPI enabled only when all four SPI lines are peripherals.
// - Both ports enabled: output goes to UART until SPI input.
// - First port with input locks; other port blocked until reset.
// - UART alone enabled: ignore the SPI select line.
// - SPI alone enabled: ignore all UART traffic.
// - Disabled port never used, not even during startup.
// - Both ports disabled at reset: fall back to the UART.
// - Input pull-ups on after reset; configuration may turn them off.
`timescale 1ns/100ps
`default_nettype none

`include "sps_defines.svh"

module sps_top #(
  parameter int unsigned WIDTH = `SPS_BYTE_BITS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic spi_sclk_i,
  input wire logic spi_ssel_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic host_attention_n_o,
  output logic host_attention_oe_o,
  input wire logic sleep_request_io,
  input wire sps_pkg::sps_cfg_t cfg_i,
  input wire logic uart_rx_activity_i,
  input wire logic [WIDTH-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [WIDTH-1:0] rx_data_o,
  output logic rx_valid_o,
  output sps_pkg::sps_sel_t port_sel_o,
  output logic [1:0] frame_mode_o,
  output logic awake_o,
  output logic spi_pullup_en_o
);

  sps_pkg::sps_state_t state_q;
  sps_pkg::sps_state_t state_d;

  logic link_rst_q;
  logic req_tgl_q;
  logic [WIDTH-1:0] tx_word_q;
  logic pend_q;
  logic pend_d;
  logic take;
  logic rx_seen_q;

  logic ack_tgl;
  logic done_tgl;
  logic rx_tgl;
  logic [WIDTH-1:0] rx_word;

  logic ack_s;
  logic done_s;
  logic rx_s;
  logic ssel_n_s;
  logic sleep_req_s;

  logic spi_en;
  logic uart_en;
  logic in_flight;
  logic spi_active;

  // all four lines must be peripherals
  function automatic logic spi_enabled(sps_pkg::sps_cfg_t c);
    return c.spi_mosi_periph && c.spi_miso_periph &&
           c.spi_ssel_periph && c.spi_sclk_periph;
  endfunction

  function automatic logic uart_enabled(sps_pkg::sps_cfg_t c);
    return c.uart_din_periph && c.uart_dout_periph;
  endfunction

  assign spi_en = spi_enabled(cfg_i);
  assign uart_en = uart_enabled(cfg_i);
  assign spi_active = (state_q == sps_pkg::SPS_ST_SPI);

  // Pins and link-domain toggles pass two flops
  sps_sync #(.WIDTH(5)) u_sync (
    .clk_i(clk_i),
    .async_i({ack_tgl, done_tgl, rx_tgl, spi_ssel_n_i, sleep_request_io}),
    .sync_o({ack_s, done_s, rx_s, ssel_n_s, sleep_req_s})
  );

  // the link runs only on the master's clock
  sps_spi_link #(.WIDTH(WIDTH)) u_link (
    .sclk_i(spi_sclk_i),
    .ssel_n_i(spi_ssel_n_i),
    .mosi_i(spi_mosi_i),
    .rst_i(link_rst_q),
    .req_tgl_i(req_tgl_q),
    .tx_word_i(tx_word_q),
    .miso_o(spi_miso_o),
    .miso_oe_o(spi_miso_oe_o),
    .ack_tgl_o(ack_tgl),
    .done_tgl_o(done_tgl),
    .rx_tgl_o(rx_tgl),
    .rx_word_o(rx_word)
  );

  // Link state is cleared from a registered copy of the reset
  always_ff @(posedge clk_i) begin
    link_rst_q <= reset_i;
  end

  // Port selection
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sps_pkg::SPS_ST_INIT: begin
        // single enabled port chosen before any traffic
        if (spi_en && uart_en) begin
          state_d = sps_pkg::SPS_ST_OPEN;
        end else if (spi_en) begin
          state_d = sps_pkg::SPS_ST_SPI;
        end else begin
          state_d = sps_pkg::SPS_ST_UART;
        end
      end
      sps_pkg::SPS_ST_OPEN: begin
        if (!ssel_n_s) begin
          state_d = sps_pkg::SPS_ST_SPI;
        end else if (uart_rx_activity_i) begin
          state_d = sps_pkg::SPS_ST_UART;
        end
      end
      sps_pkg::SPS_ST_UART: begin
        state_d = sps_pkg::SPS_ST_UART;
      end
      sps_pkg::SPS_ST_SPI: begin
        state_d = sps_pkg::SPS_ST_SPI;
      end
    endcase
  end

  // lock held until the next reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= sps_pkg::SPS_ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // UART carries output while still open
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      port_sel_o <= '0;
    end else begin
      port_sel_o.uart_rx_en <= (state_d == sps_pkg::SPS_ST_OPEN) ||
                               (state_d == sps_pkg::SPS_ST_UART);
      port_sel_o.uart_tx_en <= (state_d == sps_pkg::SPS_ST_OPEN) ||
                               (state_d == sps_pkg::SPS_ST_UART);
      port_sel_o.spi_en <= (state_d == sps_pkg::SPS_ST_SPI);
    end
  end

  // Transmit word handed to the link by toggle handshake
  assign take = tx_valid_i && tx_ready_o;
  assign pend_d = take || (pend_q && (ack_s != req_tgl_q));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pend_q <= 1'b0;
      req_tgl_q <= 1'b0;
      tx_word_q <= `SPS_FILLER_BYTE;
    end else begin
      pend_q <= pend_d;
      if (take) begin
        req_tgl_q <= ~req_tgl_q;
        tx_word_q <= tx_data_i;
      end
    end
  end

  // no output on SPI unless it is the locked port
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= (state_d == sps_pkg::SPS_ST_SPI) && !pend_d && !take;
    end
  end

  // Taken bytes not yet shifted out keep attention asserted
  assign in_flight = (ack_s != done_s);

  // attention while anything is queued or shifting
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      host_attention_n_o <= `SPS_ATTN_N_RST;
    end else begin
      host_attention_n_o <= !(spi_active &&
                             (tx_valid_i || pend_q || in_flight));
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      host_attention_oe_o <= 1'b1;
    end else begin
      host_attention_oe_o <= 1'b1;
    end
  end

  // every byte received while SPI is locked is passed on; framing is checked upstream
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_seen_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      rx_seen_q <= rx_s;
      // input on the other port is blocked
      rx_valid_o <= (rx_s != rx_seen_q) && spi_active;
      if ((rx_s != rx_seen_q) && spi_active) begin
        rx_data_o <= rx_word;
      end
    end
  end

  // SPI always uses unescaped API frames
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      frame_mode_o <= `SPS_API_UNESCAPED;
    end else if (state_d == sps_pkg::SPS_ST_SPI) begin
      frame_mode_o <= `SPS_API_UNESCAPED;
    end else begin
      frame_mode_o <= cfg_i.api_mode_setting;
    end
  end

  // Pin sleep source
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      awake_o <= `SPS_AWAKE_RST;
    end else if (cfg_i.sleep_mode_setting != `SPS_SM_PIN_SLEEP) begin
      awake_o <= 1'b1;
    end else if (cfg_i.sleep_request_periph) begin
      awake_o <= !sleep_req_s;
    end else if (cfg_i.spi_ssel_periph) begin
      awake_o <= !ssel_n_s;
    end else begin
      awake_o <= 1'b1;
    end
  end

  // pull-ups on after reset until configuration clears them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      spi_pullup_en_o <= `SPS_PULLUP_RST;
    end else begin
      spi_pullup_en_o <= cfg_i.pullup_control;
    end
  end

endmodule // sps_top

`default_nettype wire

/* File: pkg/sps_defines.svh */
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Byte framing on the link
`define SPS_BYTE_BITS 8
`define SPS_FILLER_BYTE 8'hff
`define SPS_FRAME_START 8'h7e

// Configuration encodings
`define SPS_SM_PIN_SLEEP 3'h1
`define SPS_API_UNESCAPED 2'h1

// Reset values
`define SPS_PULLUP_RST 1'b1
`define SPS_ATTN_N_RST 1'b1
`define SPS_AWAKE_RST 1'b1

// Link rate ceiling and the core cycles in one link bit
`define SPS_CLK_MHZ 100
`define SPS_MAX_SCLK_KBPS 6000
`define SPS_BIT_CYCLES \
  ((`SPS_CLK_MHZ * 1000 + `SPS_MAX_SCLK_KBPS - 1) / `SPS_MAX_SCLK_KBPS)

`endif

/* File: pkg/sps_pkg.sv */
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_ST_INIT,
    SPS_ST_OPEN,
    SPS_ST_UART,
    SPS_ST_SPI
  } sps_state_t;

  typedef struct packed {
    logic uart_din_periph;
    logic uart_dout_periph;
    logic spi_mosi_periph;
    logic spi_miso_periph;
    logic spi_ssel_periph;
    logic spi_sclk_periph;
    logic sleep_request_periph;
    logic [2:0] sleep_mode_setting;
    logic [1:0] api_mode_setting;
    logic pullup_control;
  } sps_cfg_t;

  typedef struct packed {
    logic uart_rx_en;
    logic uart_tx_en;
    logic spi_en;
  } sps_sel_t;

endpackage

/* File: hdl/sps_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module sps_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end

endmodule // sps_sync

`default_nettype wire

/* File: hdl/sps_spi_link.sv */
`timescale 1ns/100ps
`default_nettype none

`include "sps_defines.svh"

module sps_spi_link #(
  parameter int unsigned WIDTH = `SPS_BYTE_BITS
) (
  input wire logic sclk_i,
  input wire logic ssel_n_i,
  input wire logic mosi_i,
  input wire logic rst_i,
  input wire logic req_tgl_i,
  input wire logic [WIDTH-1:0] tx_word_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic ack_tgl_o,
  output logic done_tgl_o,
  output logic rx_tgl_o,
  output logic [WIDTH-1:0] rx_word_o
);

  localparam int unsigned CW = $clog2(WIDTH);
  localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

  logic req_s;
  logic [CW-1:0] cnt_q;
  logic [WIDTH-1:0] tx_q;
  logic [WIDTH-1:0] rx_sh_q;
  logic tx_data_q;
  logic take;

  sps_sync #(.WIDTH(1)) u_req_sync (
    .clk_i(sclk_i),
    .async_i(req_tgl_i),
    .sync_o(req_s)
  );

  assign take = (cnt_q == LAST) && (req_s != ack_tgl_o);

  // bit position, counted on rising edges
  always_ff @(posedge sclk_i or posedge ssel_n_i) begin
    if (ssel_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sh_q <= '0;
      rx_word_o <= '0;
      rx_tgl_o <= 1'b0;
    end else begin
      rx_sh_q <= {rx_sh_q[WIDTH-2:0], mosi_i};
      if (cnt_q == LAST) begin
        rx_word_o <= {rx_sh_q[WIDTH-2:0], mosi_i};
        rx_tgl_o <= ~rx_tgl_o;
      end
    end
  end

  // filler byte when nothing queued, next byte chosen
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_q <= `SPS_FILLER_BYTE;
      tx_data_q <= 1'b0;
      ack_tgl_o <= 1'b0;
      done_tgl_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      tx_q <= take ? tx_word_i : `SPS_FILLER_BYTE;
      tx_data_q <= take;
      if (take) begin
        ack_tgl_o <= ~ack_tgl_o;
      end
      if (tx_data_q) begin
        done_tgl_o <= ~done_tgl_o;
      end
    end
  end

  // drive on falling edge so the master samples on rising
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_o <= 1'b1;
    end else begin
      miso_o <= tx_q[LAST - cnt_q];
    end
  end

  // release the line the moment select goes high
  always_ff @(negedge sclk_i or posedge ssel_n_i) begin
    if (ssel_n_i) begin
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= 1'b1;
    end
  end

endmodule // sps_spi_link

`default_nettype wire

/* File: tb/sps_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module sps_top_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic spi_ssel_n_i,
  input wire logic spi_miso_oe_o,
  input wire logic host_attention_n_o,
  input wire logic host_attention_oe_o,
  input wire sps_pkg::sps_cfg_t cfg_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire sps_pkg::sps_sel_t port_sel_o,
  input wire logic [1:0] frame_mode_o,
  input wire logic awake_o,
  input wire logic spi_pullup_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic spi_only;
  // UART input pin off, all four link pins on
  assign spi_only = !cfg_i.uart_din_periph && (&cfg_i[10:7]);
  sequence s_take;
    tx_valid_i && tx_ready_o;
  endsequence
  sequence s_queued;
    !tx_ready_o && !host_attention_n_o;
  endsequence
  a_attn_driven: assert property (host_attention_oe_o)
    else $error("attention not driven");
  a_miso_release: assert property (spi_ssel_n_i |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  a_lock_spi: assert property (port_sel_o.spi_en |=> port_sel_o.spi_en)
    else $error("spi lock lost");
  a_block_uart: assert property (port_sel_o.spi_en |->
    !port_sel_o.uart_tx_en && !port_sel_o.uart_rx_en)
    else $error("uart open while spi locked");
  a_spi_only: assert property (spi_only |-> !port_sel_o.uart_tx_en)
    else $error("disabled uart used");
  a_tx_refused: assert property (!port_sel_o.spi_en &&
    !$past(port_sel_o.spi_en) |-> !tx_ready_o)
    else $error("tx ready without spi lock");
  a_mode_one: assert property (port_sel_o.spi_en &&
    $past(port_sel_o.spi_en) |-> frame_mode_o == 2'h1)
    else $error("frame mode not one on spi");
  a_attn_take: assert property (s_take |=> s_queued)
    else $error("attention not low after handover");
  a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("rx valid longer than one cycle");
  a_pullup_cfg: assert property (!$past(reset_i) |->
    spi_pullup_en_o == $past(cfg_i.pullup_control))
    else $error("pullup does not follow control");
  a_awake_fixed: assert property (!$past(reset_i) && $stable(cfg_i) &&
    !cfg_i.sleep_request_periph && !cfg_i.spi_ssel_periph |-> awake_o)
    else $error("asleep without sleep pin");
endmodule // sps_top_checker

bind sps_top sps_top_checker i_chk (.clk_i(clk_i), .reset_i(reset_i),
  .spi_ssel_n_i(spi_ssel_n_i), .spi_miso_oe_o(spi_miso_oe_o),
  .host_attention_n_o(host_attention_n_o),
  .host_attention_oe_o(host_attention_oe_o), .cfg_i(cfg_i),
  .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .rx_valid_o(rx_valid_o), .port_sel_o(port_sel_o),
  .frame_mode_o(frame_mode_o), .awake_o(awake_o),
  .spi_pullup_en_o(spi_pullup_en_o));

`default_nettype wire

/* File: tb/sps_spi_master.sv */
`timescale 1ns/100ps
`default_nettype none

module sps_spi_master (
  output logic sclk_o,
  output logic ssel_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    ssel_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic sel(input logic lvl);
    #2 ssel_n_o = lvl;
    if (lvl) begin
      mosi_o = 1'b1;
    end
    #16;
  endtask
  // bit period fixed by the model, never shorter
  // clock idles low, msb first, one byte each way
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    #2;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = d[i];
      #16 sclk_o = 1'b1;
      r[i] = miso_i;
      #32 sclk_o = 1'b0;
      #16;
    end
  endtask
endmodule // sps_spi_master

`default_nettype wire

/* File: tb/sps_top_test.sv */
`timescale 1ns/100ps
`default_nettype none

module sps_top_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  sps_pkg::sps_cfg_t cfg = '0;
  logic uart_act = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic sleep_req = 1'b0;
  wire logic sclk, ssel_n, mosi, miso, miso_oe, miso_w, attn_n, tx_ready;
  wire logic rx_valid, awake, pullup_en, attn_oe;
  wire logic [7:0] rx_data;
  wire logic [1:0] frame_mode;
  wire sps_pkg::sps_sel_t port_sel;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] rxq[$];

  assign miso_w = miso_oe ? miso : 1'bz;
  sps_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .spi_sclk_i(sclk),
    .spi_ssel_n_i(ssel_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .host_attention_n_o(attn_n),
    .host_attention_oe_o(attn_oe), .sleep_request_io(sleep_req),
    .cfg_i(cfg),
    .uart_rx_activity_i(uart_act), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .port_sel_o(port_sel),
    .frame_mode_o(frame_mode), .awake_o(awake),
    .spi_pullup_en_o(pullup_en));
  sps_spi_master i_mst (.sclk_o(sclk), .ssel_n_o(ssel_n), .mosi_o(mosi),
    .miso_i(miso_w));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic sps_pkg::sps_cfg_t mk(input logic u, input logic s,
                                           input logic sl);
    return {u, u, s, s, s, s, sl, 3'h1, 2'h2, 1'b1};
  endfunction
  task automatic do_reset(input sps_pkg::sps_cfg_t c);
    @(posedge clk_i);
    cfg <= c;
    reset_i <= 1'b1;
    rxq.delete();
    @(posedge clk_i);
    #1 chk("attn_n", 8'h1, 8'(attn_n));
    chk("attn_oe", 8'h1, 8'(attn_oe));
    chk("pullup_en", 8'h1, 8'(pullup_en));
    @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic ssel(input logic lvl);
    @(posedge clk_i);
    i_mst.sel(lvl);
  endtask
  task automatic spi(input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    i_mst.xfer(d, r);
  endtask
  task automatic pulse_uart();
    @(posedge clk_i);
    uart_act <= 1'b1;
    @(posedge clk_i);
    uart_act <= 1'b0;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  task automatic t_spi();
    logic [7:0] r;
    logic [7:0] ex [4] = '{8'h7e, 8'h11, 8'h22, 8'h33};
    do_reset(mk(1'b1, 1'b1, 1'b0));
    chk("uart_tx_en", 8'h1, 8'(port_sel.uart_tx_en));
    ssel(1'b0);
    settle();
    pulse_uart();
    settle();
    chk("port_sel", 8'h1, 8'(port_sel));
    chk("frame_mode", 8'h1, 8'(frame_mode));
    spi(8'h7e, r);
    for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("tx_ready", 8'h1, 8'(tx_ready));
    @(posedge clk_i);
    tx_data <= 8'ha5;
    tx_valid <= 1'b1;
    @(posedge clk_i);
    tx_valid <= 1'b0;
    @(posedge clk_i);
    #1 chk("attn_n", 8'h0, 8'(attn_n));
    spi(8'h11, r);
    chk("miso", 8'hff, r);
    chk("attn_n", 8'h0, 8'(attn_n));
    spi(8'h22, r);
    chk("miso", 8'ha5, r);
    spi(8'h33, r);
    chk("miso", 8'hff, r);
    chk("miso_oe", 8'h1, 8'(miso_oe));
    ssel(1'b1);
    settle();
    chk("miso_oe", 8'h0, 8'(miso_oe));
    chk("attn_n", 8'h1, 8'(attn_n));
    chk("rx_count", 8'h4, 8'(rxq.size()));
    for (int i = 0; i < 4; i++) begin
      chk("rx_data", ex[i], rxq[i]);
    end
    $display("test spi done");
  endtask

  task automatic t_uart();
    do_reset(mk(1'b1, 1'b1, 1'b0));
    pulse_uart();
    ssel(1'b0);
    settle();
    chk("port_sel", 8'h6, 8'(port_sel));
    chk("tx_ready", 8'h0, 8'(tx_ready));
    chk("frame_mode", 8'h2, 8'(frame_mode));
    ssel(1'b1);
    $display("test uart done");
  endtask

  task automatic t_single();
    sps_pkg::sps_cfg_t cs [4];
    logic [7:0] ex [4] = '{8'h6, 8'h1, 8'h6, 8'h6};
    cs[0] = mk(1'b1, 1'b0, 1'b0);
    cs[1] = mk(1'b0, 1'b1, 1'b0);
    cs[2] = mk(1'b0, 1'b0, 1'b0);
    cs[3] = mk(1'b1, 1'b1, 1'b0);
    cs[3].spi_sclk_periph = 1'b0;
    for (int i = 0; i < 4; i++) begin
      do_reset(cs[i]);
      chk("port_sel", ex[i], 8'(port_sel));
      ssel(1'b0);
      pulse_uart();
      settle();
      chk("port_sel", ex[i], 8'(port_sel));
      ssel(1'b1);
    end
    $display("test single done");
  endtask

  task automatic t_sleep();
    do_reset(mk(1'b1, 1'b1, 1'b1));
    ssel(1'b0);
    sleep_req <= 1'b1;
    settle();
    chk("awake", 8'h0, 8'(awake));
    cfg.sleep_request_periph <= 1'b0;
    settle();
    chk("awake", 8'h1, 8'(awake));
    ssel(1'b1);
    settle();
    chk("awake", 8'h0, 8'(awake));
    cfg.spi_ssel_periph <= 1'b0;
    cfg.pullup_control <= 1'b0;
    settle();
    chk("awake", 8'h1, 8'(awake));
    chk("pullup_en", 8'h0, 8'(pullup_en));
    $display("test sleep done");
  endtask

  initial begin
    t_spi();
    t_uart();
    t_single();
    t_sleep();
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule // sps_top_test

`default_nettype wire
